/* File: core/ltc_core.sv */
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ltc_core #(
  parameter int         N_LP       = 2,
  parameter bit         MT_SUPPORT = 1'b1,
  parameter logic [7:0] LP_AVAIL   = 8'h02
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  input  wire logic [ltc_pkg::AXI_AW-1:0]          i_awaddr,
  input  wire logic                                i_awvalid,
  output logic                                     o_awready,
  input  wire logic [31:0]                         i_wdata,
  input  wire logic [3:0]                          i_wstrb,
  input  wire logic                                i_wvalid,
  output logic                                     o_wready,
  output logic [1:0]                               o_bresp,
  output logic                                     o_bvalid,
  input  wire logic                                i_bready,
  input  wire logic [ltc_pkg::AXI_AW-1:0]          i_araddr,
  input  wire logic                                i_arvalid,
  output logic                                     o_arready,
  output logic [31:0]                              o_rdata,
  output logic [1:0]                               o_rresp,
  output logic                                     o_rvalid,
  input  wire logic                                i_rready,
  input  wire logic [1:0]                          i_pkg_id,
  input  wire logic [1:0]                          i_cluster_id,
  input  wire logic                                i_boot_pkg,
  input  wire logic                                i_msg_valid,
  input  wire ltc_pkg::ltc_msg_s                   i_msg,
  output logic                                     o_msg_ack,
  output logic                                     o_xpi_valid,
  output ltc_pkg::ltc_msg_s                        o_xpi,
  input  wire logic                                i_xpi_ack,
  input  wire logic [N_LP-1:0]                     i_stop_op,
  input  wire logic [N_LP-1:0]                     i_res_req,
  input  wire logic [N_LP-1:0]                     i_spin_hint,
  input  wire logic [N_LP-1:0]                     i_loop_exit,
  output logic [N_LP-1:0]                          o_halted,
  output logic [N_LP-1:0]                          o_wake,
  output logic [N_LP-1:0][7:0]                     o_wake_vec,
  output logic [N_LP-1:0][ltc_pkg::ID_W-1:0]       o_unit_id,
  output logic [N_LP-1:0]                          o_res_grant,
  output logic [N_LP-1:0]                          o_flush,
  output logic [N_LP-1:0]                          o_issue_en
);
  localparam int         LPW = $clog2(N_LP);
  localparam logic [3:0] GAP = 4'(ltc_pkg::SPIN_GAP_CYC);

  logic [4:0]                       strap_s1, strap_s2;
  logic                             msg_v_s1, msg_v_s2, xack_s1, xack_s2;
  ltc_pkg::ltc_msg_s                msg_s1, msg_s2;
  ltc_pkg::ltc_init_e               state, next_state;
  logic [1:0]                       init_cnt, next_init_cnt;
  logic                             init_done, take;
  logic [N_LP-1:0]                  halted, next_halted, wake, spin, issue, flush, grant, next_grant;
  logic [N_LP-1:0][ltc_pkg::ID_W-1:0] ids;
  logic [N_LP-1:0][7:0]             vecs;
  logic [N_LP-1:0]                  elig, halt_wr, next_halt_wr;
  logic [LPW-1:0]                   rr_ptr, next_ptr;
  int                               idx;
  logic                             aw_full, next_aw_full, w_full, next_w_full, wr_go;
  logic [ltc_pkg::AXI_AW-1:0]       aw_addr, next_aw_addr;
  logic [31:0]                      w_data, next_w_data, sel, next_sel, rdata, next_rdata;
  logic [3:0]                       w_strb, next_w_strb;
  logic                             awready, next_awready, wready, next_wready, arready, next_arready;
  logic                             bvalid, next_bvalid, rvalid, next_rvalid, msg_ack, next_msg_ack;
  logic [1:0]                       bresp, next_bresp, rresp, next_rresp;
  logic                             xpi_valid, next_xpi_valid, xpi_busy;
  ltc_pkg::ltc_msg_s                xpi_msg, next_xpi_msg;

  // Pin synchronisers; data of the router message is held stable while its valid is high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
      msg_v_s1 <= 1'b0;
      msg_v_s2 <= 1'b0;
      msg_s1   <= '0;
      msg_s2   <= '0;
      xack_s1  <= 1'b0;
      xack_s2  <= 1'b0;
    end else begin
      strap_s1 <= {i_boot_pkg, i_cluster_id, i_pkg_id};
      strap_s2 <= strap_s1;
      msg_v_s1 <= i_msg_valid;
      msg_v_s2 <= msg_v_s1;
      msg_s1   <= i_msg;
      msg_s2   <= msg_s1;
      xack_s1  <= i_xpi_ack;
      xack_s2  <= xack_s1;
    end
  end

  // Init sequence: wait for straps to settle, then hand out IDs once
  always_comb begin
    next_state    = state;
    next_init_cnt = init_cnt;
    init_done     = 1'b0;
    case (state)
      ltc_pkg::ST_INIT: begin
        next_init_cnt = init_cnt + 2'h1;
        if (init_cnt == ltc_pkg::INIT_WAIT) begin
          next_state = ltc_pkg::ST_RUN;
          init_done  = 1'b1;
        end
      end
      default: next_state = ltc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state    <= ltc_pkg::ST_INIT;
      init_cnt <= 2'h0;
    end else begin
      state    <= next_state;
      init_cnt <= next_init_cnt;
    end
  end

  // Router messages are taken only once IDs exist, so none is lost in init
  assign take = (state == ltc_pkg::ST_RUN) && msg_v_s2 && !msg_ack;

  // Per logical processor: ID, halt/wake, spin-wait throttle, flush
  for (genvar g = 0; g < N_LP; g++) begin : g_lp
    logic [3:0] gap, next_gap;
    logic       hit, next_spin, next_issue, next_flush;
    logic [ltc_pkg::ID_W-1:0] next_id;
    logic [7:0] next_vec;
    always_comb begin
      hit            = take && (msg_s2.dest == ids[g]);
      next_id        = ids[g];
      next_vec       = vecs[g];
      next_halted[g] = halted[g];
      if (init_done) begin
        next_id        = {strap_s2[3:2], strap_s2[1:0], 1'(g)};
        next_halted[g] = !(g == 0 && strap_s2[4]);
      end else if (hit) begin
        next_halted[g] = 1'b0;
        next_vec       = msg_s2.vector;
      end else if (i_stop_op[g] || halt_wr[g]) begin
        next_halted[g] = 1'b1;
      end
      // Hint seen anywhere in the loop counts for its exit
      next_spin  = !i_loop_exit[g] && (spin[g] || i_spin_hint[g]);
      next_flush = i_loop_exit[g] && !(spin[g] || i_spin_hint[g]);
      next_gap   = 4'h0;
      next_issue = 1'b1;
      if (next_spin) begin
        next_issue = (gap == 4'h0);
        next_gap   = (gap == 4'h0) ? GAP - 4'h1 : gap - 4'h1;
      end
      if (next_halted[g]) begin
        next_issue = 1'b0;
      end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        ids[g]    <= '0;
        vecs[g]   <= 8'h00;
        halted[g] <= 1'b1;
        wake[g]   <= 1'b0;
        spin[g]   <= 1'b0;
        gap       <= 4'h0;
        issue[g]  <= 1'b0;
        flush[g]  <= 1'b0;
      end else begin
        ids[g]    <= next_id;
        vecs[g]   <= next_vec;
        halted[g] <= next_halted[g];
        wake[g]   <= hit;
        spin[g]   <= next_spin;
        gap       <= next_gap;
        issue[g]  <= next_issue;
        flush[g]  <= next_flush;
      end
    end
  end

  // Round-robin grant; halted ones drop out at once and rejoin on wake
  always_comb begin
    elig       = i_res_req & ~next_halted;
    next_grant = '0;
    next_ptr   = rr_ptr;
    idx        = 0;
    for (int k = 1; k <= N_LP; k++) begin
      idx = (int'(rr_ptr) + k) % N_LP;
      if (elig[idx] && next_grant == '0) begin
        next_grant[idx] = 1'b1;
        next_ptr        = LPW'(idx);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      grant  <= '0;
      rr_ptr <= '0;
    end else begin
      grant  <= next_grant;
      rr_ptr <= next_ptr;
    end
  end

  // Lite slave: address and data held independently, one response each
  always_comb begin
    next_aw_full   = aw_full;
    next_aw_addr   = aw_addr;
    next_w_full    = w_full;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_sel       = sel;
    next_halt_wr   = '0;
    next_xpi_valid = xpi_valid;
    next_xpi_msg   = xpi_msg;
    xpi_busy       = xpi_valid || xack_s2;
    wr_go          = aw_full && w_full && !bvalid;
    if (i_awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (xack_s2) begin
      next_xpi_valid = 1'b0;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ltc_pkg::RESP_OKAY;
      if (aw_addr == ltc_pkg::ADDR_SEL) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            next_sel[8*b +: 8] = w_data[8*b +: 8];
          end
        end
      end else if (aw_addr == ltc_pkg::ADDR_CMD) begin
        // A second send before the handshake ends would overrun the link
        if (xpi_busy) begin
          next_bresp = ltc_pkg::RESP_SLVERR;
        end else begin
          next_xpi_valid      = 1'b1;
          next_xpi_msg.dest   = w_data[ltc_pkg::CMD_DEST_LSB +: 5];
          next_xpi_msg.vector = w_data[ltc_pkg::CMD_VEC_LSB +: 8];
        end
      end else if (aw_addr == ltc_pkg::ADDR_HALT) begin
        next_halt_wr = w_data[N_LP-1:0];
      end else if (aw_addr != ltc_pkg::ADDR_FEAT && aw_addr != ltc_pkg::ADDR_COUNT &&
                   aw_addr != ltc_pkg::ADDR_STAT && aw_addr != ltc_pkg::ADDR_IDS &&
                   aw_addr != ltc_pkg::ADDR_VEC) begin
        next_bresp = ltc_pkg::RESP_SLVERR;
      end
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    if (i_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = ltc_pkg::RESP_OKAY;
      if (i_araddr == ltc_pkg::ADDR_SEL) begin
        next_rdata = sel;
      end else if (i_araddr == ltc_pkg::ADDR_FEAT) begin
        next_rdata[ltc_pkg::FEAT_MT_BIT] = MT_SUPPORT && (sel == ltc_pkg::SEL_IDENT);
      end else if (i_araddr == ltc_pkg::ADDR_COUNT) begin
        if (sel == ltc_pkg::SEL_IDENT) begin
          next_rdata[ltc_pkg::CNT_LSB +: 8] = MT_SUPPORT ? LP_AVAIL : ltc_pkg::CNT_SINGLE;
        end
      end else if (i_araddr == ltc_pkg::ADDR_STAT) begin
        next_rdata[N_LP-1:0]              = halted;
        next_rdata[ltc_pkg::STAT_BUSY_BIT] = xpi_busy;
      end else if (i_araddr == ltc_pkg::ADDR_IDS) begin
        for (int j = 0; j < N_LP; j++) begin
          next_rdata[8*j +: ltc_pkg::ID_W] = ids[j];
        end
      end else if (i_araddr == ltc_pkg::ADDR_VEC) begin
        for (int j = 0; j < N_LP; j++) begin
          next_rdata[8*j +: 8] = vecs[j];
        end
      end else if (i_araddr != ltc_pkg::ADDR_CMD && i_araddr != ltc_pkg::ADDR_HALT) begin
        next_rresp = ltc_pkg::RESP_SLVERR;
      end
    end else if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
    next_msg_ack = msg_v_s2 && (msg_ack || state == ltc_pkg::ST_RUN);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_full   <= 1'b0;
      aw_addr   <= '0;
      w_full    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      arready   <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= 2'h0;
      sel       <= ltc_pkg::SEL_RESET;
      halt_wr   <= '0;
      xpi_valid <= 1'b0;
      xpi_msg   <= '0;
      msg_ack   <= 1'b0;
    end else begin
      aw_full   <= next_aw_full;
      aw_addr   <= next_aw_addr;
      w_full    <= next_w_full;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      awready   <= next_awready;
      wready    <= next_wready;
      arready   <= next_arready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      sel       <= next_sel;
      halt_wr   <= next_halt_wr;
      xpi_valid <= next_xpi_valid;
      xpi_msg   <= next_xpi_msg;
      msg_ack   <= next_msg_ack;
    end
  end

  // Outputs, all straight from flip-flops
  assign o_awready   = awready;
  assign o_wready    = wready;
  assign o_arready   = arready;
  assign o_bvalid    = bvalid;
  assign o_bresp     = bresp;
  assign o_rvalid    = rvalid;
  assign o_rdata     = rdata;
  assign o_rresp     = rresp;
  assign o_msg_ack   = msg_ack;
  assign o_xpi_valid = xpi_valid;
  assign o_xpi       = xpi_msg;
  assign o_halted    = halted;
  assign o_wake      = wake;
  assign o_wake_vec  = vecs;
  assign o_unit_id   = ids;
  assign o_res_grant = grant;
  assign o_flush     = flush;
  assign o_issue_en  = issue;

  // Checks on LP0 and LP1; the ID layout limits N_LP to two
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  feat_flag_a: assert property (
    i_arvalid && arready && i_araddr == ltc_pkg::ADDR_FEAT
    |=> rdata[ltc_pkg::FEAT_MT_BIT] == (MT_SUPPORT && $past(sel) == ltc_pkg::SEL_IDENT))
    else $error("feature flag wrong");
  sel_gate_a: assert property (
    i_arvalid && arready && sel != ltc_pkg::SEL_IDENT &&
    (i_araddr == ltc_pkg::ADDR_FEAT || i_araddr == ltc_pkg::ADDR_COUNT) |=> rdata == 32'h0000_0000)
    else $error("identification data without selector");
  lp_count_a: assert property (
    i_arvalid && arready && i_araddr == ltc_pkg::ADDR_COUNT && sel == ltc_pkg::SEL_IDENT
    |=> rdata[23:16] == (MT_SUPPORT ? LP_AVAIL : 8'h01) && rvalid)
    else $error("processor count wrong");
  id_layout_a: assert property (
    init_done |=> ids[0] == {$past(strap_s2[3:0]), 1'b0} && ids[1][0] && ids[1][4:1] == ids[0][4:1])
    else $error("unit id layout wrong");
  unique_id_a: assert property (
    state == ltc_pkg::ST_RUN |-> ids[0] != ids[1])
    else $error("unit ids collide");
  boot_halt_a: assert property (
    init_done |=> halted[1] && halted[0] == !$past(strap_s2[4]))
    else $error("boot halt state wrong");
  wake_vec_a: assert property (
    take && msg_s2.dest == ids[1] |=> !halted[1] && wake[1] && vecs[1] == $past(msg_s2.vector))
    else $error("wake did not follow message");
  stop_halt_a: assert property (
    state == ltc_pkg::ST_RUN && i_stop_op[1] && !(take && msg_s2.dest == ids[1])
    |=> halted[1] && halted[0] == $past(next_halted[0]))
    else $error("halt not taken");
  release_a: assert property (
    (grant & halted) == '0)
    else $error("grant to halted processor");
  rr_turn_a: assert property (
    grant[0] && (&elig) |=> grant[1])
    else $error("round robin skipped");
  xpi_send_a: assert property (
    wr_go && aw_addr == ltc_pkg::ADDR_CMD && !xpi_busy |=> xpi_valid && xpi_msg.dest == $past(w_data[4:0]))
    else $error("command write did not send");
  flush_a: assert property (
    i_loop_exit[0] && !spin[0] && !i_spin_hint[0] |=> flush[0])
    else $error("missing flush");
  no_flush_a: assert property (
    i_loop_exit[0] && spin[0] |=> !flush[0])
    else $error("flush despite hint");
  depipe_a: assert property (
    issue[0] && spin[0] ##1 spin[0] |-> !issue[0])
    else $error("spin loop not throttled");

  wake_c: cover property (take ##1 wake[1]);
  flush_c: cover property (flush[0]);
  xpi_c: cover property (xpi_valid ##[1:20] xack_s2);
  share_c: cover property (grant[0] ##1 grant[1]);
endmodule
`default_nettype wire

/* File: shared/ltc_pkg.sv */
package ltc_pkg;
  // Register byte offsets on the lite bus
  localparam int         AXI_AW      = 8;
  localparam logic [7:0] ADDR_SEL    = 8'h00;
  localparam logic [7:0] ADDR_FEAT   = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0C;
  localparam logic [7:0] ADDR_CMD    = 8'h10;
  localparam logic [7:0] ADDR_HALT   = 8'h14;
  localparam logic [7:0] ADDR_IDS    = 8'h18;
  localparam logic [7:0] ADDR_VEC    = 8'h1C;
  // Field layouts and reset values
  localparam logic [31:0] SEL_IDENT     = 32'h0000_0001;
  localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
  localparam int          FEAT_MT_BIT   = 28;
  localparam int          CNT_LSB       = 16;
  localparam logic [7:0]  CNT_SINGLE    = 8'h01;
  localparam int          STAT_BUSY_BIT = 8;
  localparam int          CMD_DEST_LSB  = 0;
  localparam int          CMD_VEC_LSB   = 8;
  localparam int          ID_W          = 5;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Timing: strap settle wait and spin-wait issue gap
  localparam logic [1:0]  INIT_WAIT     = 2'h3;
  localparam int          CLK_NS        = 50;
  localparam int          SPIN_GAP_NS   = 250;
  localparam int          SPIN_GAP_CYC  = (SPIN_GAP_NS + CLK_NS - 1) / CLK_NS;
  // Interrupt message carrier
  typedef struct packed {
    logic [4:0] dest;
    logic [7:0] vector;
  } ltc_msg_s;
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } ltc_init_e;
endpackage

/* File: tb/ltc_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ltc_far_model (
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_send,
  input  wire ltc_pkg::ltc_msg_s  i_send_msg,
  input  wire logic               i_slow,
  output ltc_pkg::ltc_msg_s       o_msg,
  output logic                    o_msg_valid,
  input  wire logic               i_msg_ack,
  input  wire logic               i_xpi_valid,
  input  wire ltc_pkg::ltc_msg_s  i_xpi,
  output logic                    o_xpi_ack,
  output ltc_pkg::ltc_msg_s       o_got
);
  logic       busy;
  logic [2:0] cnt;
  // Router side and remote processor side of the message links
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_msg_valid <= 1'b0;
      o_msg       <= '0;
      busy        <= 1'b0;
      cnt         <= 3'h0;
      o_xpi_ack   <= 1'b0;
      o_got       <= '0;
    end else begin
      // Forward a request to one processor, hold it until acked
      if (i_send && !busy) begin
        o_msg_valid <= 1'b1;
        o_msg       <= i_send_msg;
        busy        <= 1'b1;
      end else if (o_msg_valid && i_msg_ack) begin
        o_msg_valid <= 1'b0;
        o_msg       <= ~o_msg; // Released payload must not look stale
      end else if (busy && !o_msg_valid && !i_msg_ack) begin
        busy <= 1'b0;
      end
      // Slow mode keeps the sender busy long enough to test refusal
      cnt       <= i_xpi_valid ? cnt + 3'h1 : 3'h0;
      o_xpi_ack <= i_xpi_valid && (cnt >= (i_slow ? 3'h4 : 3'h0));
      if (i_xpi_valid && !o_xpi_ack) begin
        o_got <= i_xpi;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_boot_pkg, send, slow;
  logic i_msg_valid, i_xpi_ack, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_msg_ack, o_xpi_valid;
  logic [7:0]        i_awaddr, i_araddr;
  logic [31:0]       i_wdata, o_rdata, rd;
  logic [3:0]        i_wstrb;
  logic [1:0]        o_bresp, o_rresp, i_pkg_id, i_cluster_id, rs, acc;
  logic [1:0]        i_stop_op, i_res_req, i_spin_hint, i_loop_exit, o_halted, o_wake, o_res_grant;
  logic [1:0]        o_flush, o_issue_en;
  logic [1:0][7:0]   o_wake_vec;
  logic [1:0][4:0]   o_unit_id;
  ltc_pkg::ltc_msg_s i_msg, o_xpi, smsg, got;
  int                mismatches, check_count, n;
  ltc_core DUT (.*);
  ltc_far_model FAR (.i_clk, .i_reset_n, .i_send(send), .i_send_msg(smsg), .i_slow(slow), .o_msg(i_msg),
    .o_msg_valid(i_msg_valid), .i_msg_ack(o_msg_ack), .i_xpi_valid(o_xpi_valid), .i_xpi(o_xpi),
    .o_xpi_ack(i_xpi_ack), .o_got(got));
  // Free running clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // A bounded wait that ran out ends the run
  task automatic lim;
    if (n >= 50) begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) break;
    end
    i_bready <= 1'b0;
    rs = o_bresp;
    lim;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) break;
    end
    i_rready <= 1'b0;
    rd = o_rdata;
    rs = o_rresp;
    lim;
    chk(rd, exp);
  endtask
  // Grants seen over four cycles, to show who may share
  task automatic grants;
    acc = 2'b00;
    repeat (4) begin
      tick(1);
      acc |= o_res_grant;
    end
  endtask
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, send, slow} = '0;
    {i_awaddr, i_araddr, i_wdata, smsg} = '0;
    {i_stop_op, i_res_req, i_spin_hint, i_loop_exit} = '0;
    i_wstrb = 4'hF;
    i_pkg_id = 2'h2;
    i_cluster_id = 2'h1;
    i_boot_pkg = 1'b1;
    mismatches = 0;
    check_count = 0;
    i_reset_n = 1'b0;
    tick(3);
    i_reset_n <= 1'b1;
    for (n = 0; n < 50 && o_issue_en[0] !== 1'b1; n++) tick(1);
    lim;
    tick(1);
    chk(o_halted, 2'b10);
    chk(o_unit_id[0], 5'h0C);
    chk(o_unit_id[1], 5'h0D);
    rchk(ltc_pkg::ADDR_IDS, 32'h0000_0D0C);
    rchk(ltc_pkg::ADDR_STAT, 32'h0000_0002);
    $display("init test done");
    rchk(ltc_pkg::ADDR_FEAT, 32'h0000_0000);
    wr(ltc_pkg::ADDR_SEL, ltc_pkg::SEL_IDENT);
    rchk(ltc_pkg::ADDR_FEAT, 32'h1000_0000);
    rchk(ltc_pkg::ADDR_COUNT, 32'h0002_0000);
    rchk(8'h40, 32'h0000_0000);
    chk(rs, ltc_pkg::RESP_SLVERR);
    $display("ident test done");
    i_res_req <= 2'b11;
    grants;
    chk(acc, 2'b01);
    smsg <= '{dest: 5'h0D, vector: 8'h5A};
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
    for (n = 0; n < 50 && o_wake[1] !== 1'b1; n++) tick(1);
    lim;
    tick(1);
    chk(o_halted, 2'b00);
    chk(o_msg_ack, 1'b1);
    chk(o_wake_vec[1], 8'h5A);
    rchk(ltc_pkg::ADDR_VEC, 32'h0000_5A00);
    grants;
    chk(acc, 2'b11);
    $display("wake test done");
    i_stop_op <= 2'b10;
    tick(1);
    i_stop_op <= 2'b00;
    tick(1);
    chk(o_halted, 2'b10);
    chk(o_issue_en[1], 1'b0);
    $display("halt test done");
    // Slow far side keeps the first send open across the second write
    slow <= 1'b1;
    wr(ltc_pkg::ADDR_CMD, 32'h0000_330D);
    chk(rs, ltc_pkg::RESP_OKAY);
    wr(ltc_pkg::ADDR_CMD, 32'h0000_1100);
    chk(rs, ltc_pkg::RESP_SLVERR);
    rchk(ltc_pkg::ADDR_STAT, 32'h0000_0102);
    tick(20);
    chk(got, 13'h0D33);
    chk(o_xpi_valid, 1'b0);
    $display("send test done");
    i_loop_exit <= 2'b01;
    tick(1);
    i_loop_exit <= 2'b00;
    tick(1);
    chk(o_flush, 2'b01);
    i_spin_hint <= 2'b01;
    i_loop_exit <= 2'b01;
    tick(1);
    i_loop_exit <= 2'b00;
    tick(1);
    chk(o_flush, 2'b00);
    tick(3);
    n = 0;
    repeat (10) begin
      tick(1);
      n += int'(o_issue_en[0] === 1'b1);
    end
    chk(n, 2);
    // Exit with only the latched hint left
    i_spin_hint <= 2'b00;
    i_loop_exit <= 2'b01;
    tick(1);
    i_loop_exit <= 2'b00;
    tick(1);
    chk(o_flush, 2'b00);
    $display("spin test done");
    // Software halt of the boot processor through the register
    wr(ltc_pkg::ADDR_HALT, 32'h0000_0001);
    chk(rs, ltc_pkg::RESP_OKAY);
    rchk(ltc_pkg::ADDR_STAT, 32'h0000_0003);
    chk(o_issue_en, 2'b00);
    grants;
    chk(acc, 2'b00);
    $display("halt register test done");
    give_verdict;
  end
endmodule
`default_nettype wire
